// ### hdl/dma_chan_pkg.sv
package dma_chan_pkg;

	// Register byte offsets on the APB
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_STA = 8'h08;
	localparam logic [7:0] OFS_STB = 8'h0c;
	localparam logic [7:0] OFS_PAD = 8'h10;
	localparam logic [7:0] OFS_FORCE = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// Fields of channel_control_reg
	localparam int unsigned CTRL_EN_BIT = 15;
	localparam int unsigned CTRL_SIZE_BIT = 14;
	localparam int unsigned CTRL_DIR_BIT = 13;
	localparam int unsigned CTRL_HALF_BIT = 12;
	localparam int unsigned ADDRESSING_MODE_FIELD_LSB = 4;
	localparam logic [15:0] CTRL_MASK = 16'hf030;
	localparam logic [1:0] ADDRESSING_MODE_FIELD_POSTINC = 2'h0;
	localparam logic [1:0] ADDRESSING_MODE_FIELD_STATIC = 2'h1;

	// Status register fields
	localparam int unsigned STAT_BUSY_BIT = 17;
	localparam int unsigned STAT_PEND_BIT = 16;

	// Values after reset
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [15:0] PAD_RST = 16'h0000;

	// Size of the DMA window of the buffer RAM, in bytes
	localparam logic [15:0] RAM_BYTES = 16'h0800;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [15:0] BYTE_STEP = 16'h0001;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_READ = 4'b0010,
		ST_CAPT = 4'b0100,
		ST_WRITE = 4'b1000
	} xfer_state_t;

	typedef struct packed {
		logic [9:0] addr;
		logic [1:0] be;
		logic we;
		logic re;
		logic [15:0] wdata;
	} ram_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic we;
		logic re;
		logic [15:0] wdata;
	} per_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_resp_t;

	typedef struct packed {
		xfer_state_t st;
		logic [15:0] ctrl;
		logic [15:0] count;
		logic [15:0] sta;
		logic [15:0] stb;
		logic [15:0] pad;
		logic [15:0] cur_addr;
		logic [15:0] last_addr;
		logic [15:0] xaddr;
		logic [16:0] done;
		logic pend;
		logic [15:0] data;
		logic irq;
		apb_resp_t apb;
		ram_req_t ram;
		per_req_t per;
	} chan_state_t;

endpackage : dma_chan_pkg

// ### hdl/dma_channel_transfer_control.sv
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - A block completes after count plus one serviced requests.
// - A count of zero moves exactly one element per block.
// - The count is in elements, whatever the element size.
// - Buffer writes outside the DMA window drop; reads there give zero.
// - Control bit 14 clear moves words; set moves bytes.
// - Words use even buffer addresses; bytes use any address.
// - Post-increment with words advances the buffer address by two.
// - Post-increment with bytes advances the buffer address by one.
// - Direction clear: read the peripheral, write the buffer RAM.
// - Direction set: read the buffer RAM, write the peripheral.
// - A channel moves data one way only; two-way needs two channels.
// - Midpoint bit clear: interrupt at block end; set: at half.
// - Midpoint set: no end interrupt; one after (count+2)/2 moves.
// - Midpoint bit is live; clearing it mid-block gives an end interrupt.
// - Each interrupt sets the channel flag; software clears it.
// - Addressing mode resets to post-increment from the start offset.
// - Start offset reads give the latest address; programmed value kept.
// - A manual trigger forces exactly one transfer.
// - Start offsets count from the base of the DMA window.
// - Addressing mode 01 keeps the same buffer address every transfer.
module dma_channel_transfer_control (
	input wire logic mclk, // 10 MHz system clock
	input wire logic rst, // Asynchronous reset
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output dma_chan_pkg::apb_resp_t apb_out, // APB read data, ready, error
	input wire logic xfer_req, // Peripheral transfer request pulse
	output dma_chan_pkg::per_req_t per_out, // Peripheral access strobes
	input wire logic [15:0] per_rdata, // Peripheral read data
	output dma_chan_pkg::ram_req_t ram_out, // Buffer RAM access strobes
	input wire logic [15:0] ram_rdata, // Buffer RAM read data
	output logic chan_irq // Pulse to the interrupt controller
);
	import dma_chan_pkg::*;

	chan_state_t s_r;
	chan_state_t s_nxt;

	function automatic logic mapped(input logic [31:0] a);
		mapped = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0) &&
			(a[7:0] <= OFS_STATUS);
	endfunction : mapped

	// Offsets are relative to the DMA window base
	function automatic logic in_window(input logic [15:0] a);
		in_window = a < RAM_BYTES;
	endfunction : in_window

	function automatic logic [31:0] reg_read(input chan_state_t s,
		input logic [7:0] a);
		reg_read = 32'h00000000;
		unique case (a)
			OFS_CTRL: reg_read = {16'h0000, s.ctrl};
			OFS_COUNT: reg_read = {16'h0000, s.count};
			OFS_STA: reg_read = {16'h0000, s.last_addr};
			OFS_STB: reg_read = {16'h0000, s.stb};
			OFS_PAD: reg_read = {16'h0000, s.pad};
			OFS_STATUS: begin
				reg_read[15:0] = s.done[15:0];
				reg_read[STAT_PEND_BIT] = s.pend;
				reg_read[STAT_BUSY_BIT] = (s.st != ST_IDLE);
			end
			default: reg_read = 32'h00000000;
		endcase
	endfunction : reg_read

	logic en;
	logic size_byte;
	logic dir_to_per;
	logic half_sel;
	logic [1:0] addressing_mode_field;
	logic wr_take;
	logic force_now;
	logic [16:0] full_t;
	logic [16:0] half_t;
	logic [16:0] done_inc;
	logic [15:0] step;
	logic [7:0] byte_sel;

	assign en = s_r.ctrl[CTRL_EN_BIT];
	assign size_byte = s_r.ctrl[CTRL_SIZE_BIT];
	assign dir_to_per = s_r.ctrl[CTRL_DIR_BIT];
	assign half_sel = s_r.ctrl[CTRL_HALF_BIT];
	assign addressing_mode_field = s_r.ctrl[ADDRESSING_MODE_FIELD_LSB +: 2];
	assign wr_take = psel && penable && s_r.apb.pready && pwrite &&
		mapped(paddr);
	assign force_now = wr_take && (paddr[7:0] == OFS_FORCE) && pwdata[0];
	// Count is in elements, so block length ignores the size bit
	assign full_t = {1'b0, s_r.count} + 17'h00001;
	// Rounds up for an odd block length
	assign half_t = ({1'b0, s_r.count} + 17'h00002) >> 1;
	assign done_inc = s_r.done + 17'h00001;
	assign step = size_byte ? BYTE_STEP : WORD_STEP;
	assign byte_sel = s_r.xaddr[0] ? ram_rdata[15:8] : ram_rdata[7:0];

	always_comb begin
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.ram.we = 1'b0;
		s_nxt.ram.re = 1'b0;
		s_nxt.per.we = 1'b0;
		s_nxt.per.re = 1'b0;

		// APB: answer is registered, so one access cycle, no wait
		s_nxt.apb.pready = 1'b0;
		s_nxt.apb.pslverr = 1'b0;
		if (psel && !penable) begin
			s_nxt.apb.pready = 1'b1;
			s_nxt.apb.pslverr = !mapped(paddr);
			s_nxt.apb.prdata = pwrite ? 32'h00000000 :
				reg_read(s_r, paddr[7:0]);
		end
		if (wr_take) begin
			unique case (paddr[7:0])
				OFS_CTRL: s_nxt.ctrl = pwdata[15:0] & CTRL_MASK;
				OFS_COUNT: s_nxt.count = pwdata[15:0];
				OFS_STA: s_nxt.sta = pwdata[15:0];
				OFS_STB: s_nxt.stb = pwdata[15:0];
				OFS_PAD: s_nxt.pad = pwdata[15:0];
				default: s_nxt.pend = s_r.pend;
			endcase
		end

		unique case (s_r.st)
			ST_IDLE: begin
				if (!en) begin
					// Idle channel rearms from the programmed offset
					s_nxt.cur_addr = s_r.sta;
					s_nxt.last_addr = s_r.sta;
					s_nxt.done = 17'h00000;
				end else if (s_r.pend) begin
					s_nxt.pend = 1'b0;
					// Words drop the low address bit
					s_nxt.xaddr = size_byte ? s_r.cur_addr :
						{s_r.cur_addr[15:1], 1'b0};
					s_nxt.st = ST_READ;
					if (dir_to_per) begin
						// Out-of-window reads never touch the RAM
						s_nxt.ram.re = in_window(s_nxt.xaddr);
						s_nxt.ram.addr = s_nxt.xaddr[10:1];
						s_nxt.ram.be = 2'h3;
					end else begin
						s_nxt.per.re = 1'b1;
						s_nxt.per.addr = s_r.pad;
					end
				end
			end
			ST_READ: s_nxt.st = ST_CAPT;
			ST_CAPT: begin
				s_nxt.st = ST_WRITE;
				// Direction comes from one control bit, read live again in this state
				if (dir_to_per) begin
					if (!in_window(s_r.xaddr))
						s_nxt.data = 16'h0000;
					else if (size_byte)
						s_nxt.data = {8'h00, byte_sel};
					else
						s_nxt.data = ram_rdata;
					s_nxt.per.we = 1'b1;
					s_nxt.per.addr = s_r.pad;
					s_nxt.per.wdata = s_nxt.data;
				end else begin
					s_nxt.data = size_byte ? {8'h00, per_rdata[7:0]} :
						per_rdata;
					s_nxt.ram.we = in_window(s_r.xaddr);
					s_nxt.ram.addr = s_r.xaddr[10:1];
					if (size_byte) begin
						s_nxt.ram.be = s_r.xaddr[0] ? 2'h2 : 2'h1;
						s_nxt.ram.wdata = {per_rdata[7:0], per_rdata[7:0]};
					end else begin
						s_nxt.ram.be = 2'h3;
						s_nxt.ram.wdata = per_rdata;
					end
				end
			end
			ST_WRITE: begin
				s_nxt.st = ST_IDLE;
				s_nxt.last_addr = s_r.xaddr;
				// Midpoint bit sampled live at each transfer
				if (half_sel && (done_inc == half_t))
					s_nxt.irq = 1'b1;
				if (!half_sel && (done_inc == full_t))
					s_nxt.irq = 1'b1;
				if (done_inc >= full_t) begin
					// Block over: restart from the start offset
					s_nxt.done = 17'h00000;
					s_nxt.cur_addr = s_r.sta;
				end else begin
					s_nxt.done = done_inc;
					if (addressing_mode_field == ADDRESSING_MODE_FIELD_STATIC)
						s_nxt.cur_addr = s_r.xaddr;
					else
						s_nxt.cur_addr = s_r.xaddr + step;
				end
			end
		endcase

		// A request landing on the take cycle is kept: set wins
		if (!en)
			s_nxt.pend = 1'b0;
		else if (xfer_req || force_now)
			s_nxt.pend = 1'b1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.ctrl <= CTRL_RST;
			s_r.count <= COUNT_RST;
			s_r.sta <= OFFSET_RST;
			s_r.stb <= OFFSET_RST;
			s_r.pad <= PAD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_out = s_r.apb;
	assign per_out = s_r.per;
	assign ram_out = s_r.ram;
	assign chan_irq = s_r.irq;

endmodule : dma_channel_transfer_control

// ### testbench/dma_chan_sva.sv
`timescale 1ns/10ps
module dma_chan_sva (
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic [31:0] paddr, // Address
	input wire dma_chan_pkg::apb_resp_t apb_out, // Answer
	input wire dma_chan_pkg::per_req_t per_out, // Peripheral side
	input wire dma_chan_pkg::ram_req_t ram_out, // RAM side
	input wire logic chan_irq // Interrupt
);
	import dma_chan_pkg::*;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_store;
		##2 ram_out.we;
	endsequence
	sequence s_deliver;
		##2 per_out.we;
	endsequence
	a_ready_next: assert property (s_setup |=> apb_out.pready)
		else $error("pready not one cycle after setup");
	a_ready_single: assert property (apb_out.pready |=> !apb_out.pready)
		else $error("pready longer than one cycle");
	a_err_range: assert property (s_setup and paddr[7:0] > 8'h18
		|=> apb_out.pslverr)
		else $error("unmapped address not refused");
	a_err_zero: assert property (apb_out.pslverr |-> apb_out.prdata == 0)
		else $error("refused read returned data");
	a_per_to_ram: assert property (per_out.re |-> s_store)
		else $error("peripheral read not followed by RAM write");
	a_ram_to_per: assert property (ram_out.re |-> s_deliver)
		else $error("RAM read not followed by peripheral write");
	a_one_way: assert property (per_out.re |-> (!ram_out.re) [*3])
		else $error("both directions in one element");
	a_irq_source: assert property (chan_irq
		|-> $past(ram_out.we || per_out.we))
		else $error("interrupt without a write before it");
	a_irq_single: assert property (chan_irq |=> (!chan_irq) [*3])
		else $error("interrupts closer than one element");
endmodule : dma_chan_sva

bind dma_channel_transfer_control dma_chan_sva sva (.mclk, .rst, .psel,
	.penable, .paddr, .apb_out, .per_out, .ram_out, .chan_irq);

// ### testbench/dma_far_side.sv
`timescale 1ns/10ps
module dma_far_side (
	input wire logic mclk, // Clock
	input wire dma_chan_pkg::ram_req_t ram_out, // RAM strobes
	input wire dma_chan_pkg::per_req_t per_out, // Peripheral strobes
	input wire logic [15:0] per_src, // Next peripheral read value
	output logic [15:0] ram_rdata, // RAM read data
	output logic [15:0] per_rdata, // Peripheral read data
	output logic [15:0] pw // Last peripheral write
);
	import dma_chan_pkg::*;
	logic [15:0] mem [0:1023];
	initial begin
		for (int i = 0; i < 1024; i++)
			mem[i] = 16'h0000;
		ram_rdata = 16'h0000;
		per_rdata = 16'h0000;
		pw = 16'h0000;
	end
	// Outside the answer cycle the lines flip, so stale data never matches
	always @(posedge mclk) begin
		ram_rdata <= ram_out.re ? mem[ram_out.addr] : ~ram_rdata;
		per_rdata <= per_out.re ? per_src : ~per_rdata;
		if (ram_out.we && ram_out.be[0])
			mem[ram_out.addr][7:0] <= ram_out.wdata[7:0];
		if (ram_out.we && ram_out.be[1])
			mem[ram_out.addr][15:8] <= ram_out.wdata[15:8];
		if (per_out.we)
			pw <= per_out.wdata;
	end
endmodule : dma_far_side

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
	import dma_chan_pkg::*;
	logic mclk, rst, psel, penable, pwrite, xfer_req, chan_irq, e;
	logic [31:0] paddr, pwdata, q;
	logic [15:0] per_rdata, ram_rdata, per_src, pw;
	apb_resp_t apb_out;
	per_req_t per_out;
	ram_req_t ram_out;
	int fail_count = 0, n_checks = 0, irqs = 0, i0;
	dma_channel_transfer_control dut (.mclk, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .apb_out, .xfer_req, .per_out,
		.per_rdata, .ram_out, .ram_rdata, .chan_irq);
	dma_far_side m (.mclk, .ram_out, .per_out, .per_src, .ram_rdata,
		.per_rdata, .pw);
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	// Stands in for the controller's flag
	// Counts as if the channel's interrupt enable were already set
	always @(posedge mclk) if (chan_irq === 1'b1) irqs <= irqs + 1;
	task chk(input string s, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (apb_out.pready !== 1'b1 && n < 20);
		q = apb_out.prdata;
		e = apb_out.pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
		if (n == 20) begin
			fail_count++;
			finish_test;
		end
	endtask : apb
	task req(input logic [15:0] v);
		per_src <= v;
		xfer_req <= 1;
		@(posedge mclk);
		xfer_req <= 0;
		repeat (6) @(posedge mclk);
	endtask : req
	task frc;
		apb(1, OFS_FORCE, 1);
		repeat (6) @(posedge mclk);
	endtask : frc
	// Disable first so count and offsets never change under a live block
	task cfg(input logic [15:0] c0, c, s);
		apb(1, OFS_CTRL, 0);
		apb(1, OFS_COUNT, c);
		apb(1, OFS_STA, s);
		apb(1, OFS_PAD, 16'h0040);
		apb(1, OFS_CTRL, c0);
		i0 = irqs;
	endtask : cfg
	task t_reset;
		for (int i = 0; i < 5; i++) begin
			apb(0, 8'(i * 4), 0);
			chk("reset value", q, 0);
		end
		apb(0, 8'h1c, 0);
		chk("unmapped error", e, 1);
		chk("unmapped data", q, 0);
		$display("test reset done");
	endtask : t_reset
	task t_word;
		cfg(16'h8000, 2, 16'h0010);
		for (int i = 0; i < 3; i++) begin
			req(16'h1230 + 16'(i));
			chk("block end irq", irqs, i0 + (i == 2));
			chk("word store", m.mem[8 + i], 16'h1230 + i);
		end
		apb(0, OFS_STA, 0);
		chk("latest offset", q, 32'h00000014);
		$display("test word done");
	endtask : t_word
	task t_byte;
		m.mem[16'h10] = 16'hbeef;
		m.mem[16'h11] = 16'h1234;
		cfg(16'he000, 1, 16'h0021);
		frc;
		chk("byte high lane", m.pw, 16'h00be);
		frc;
		chk("byte next", m.pw, 16'h0034);
		chk("forced irq", irqs, i0 + 1);
		$display("test byte done");
	endtask : t_byte
	task t_zero;
		cfg(16'ha000, 0, 16'h0800);
		frc;
		chk("outside read", m.pw, 0);
		chk("one element", irqs, i0 + 1);
		$display("test zero done");
	endtask : t_zero
	task t_half;
		cfg(16'h9000, 3, 16'h0000);
		req(16'h0001);
		chk("no early irq", irqs, i0);
		req(16'h0002);
		chk("half irq", irqs, i0 + 1);
		apb(1, OFS_CTRL, 16'h8000);
		req(16'h0003);
		req(16'h0004);
		chk("end irq after clear", irqs, i0 + 2);
		$display("test half done");
	endtask : t_half
	task t_static;
		cfg(16'h8010, 1, 16'h0030);
		req(16'h1111);
		req(16'h2222);
		chk("same address", m.mem[16'h18], 16'h2222);
		chk("next untouched", m.mem[16'h19], 0);
		$display("test static done");
	endtask : t_static
	initial begin
		rst = 1;
		{psel, penable, pwrite, xfer_req} = '0;
		paddr = 0;
		pwdata = 0;
		per_src = 0;
		repeat (5) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		t_reset;
		t_word;
		t_byte;
		t_zero;
		t_half;
		t_static;
		finish_test;
	end
endmodule : testbench
